// ===== src/tk_pkg.sv
// Constants and types shared by the tick timer files.
// Assumes one 10 MHz system clock and a word-wide register port.
package tk_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [31:0] ADDR_CTRL_STATUS = 32'he000e010;
    localparam logic [31:0] ADDR_RELOAD      = 32'he000e014;
    localparam logic [31:0] ADDR_CURRENT     = 32'he000e018;
    localparam logic [31:0] ADDR_CALIB       = 32'he000e01c;
    localparam logic [31:0] ADDR_IRQ_STATUS  = 32'he000e020;
    localparam logic [31:0] ADDR_IRQ_MASK    = 32'he000e024;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and values
    localparam int          CNT_W         = 24;
    localparam int          BIT_ENABLE    = 0;
    localparam int          BIT_IRQ_EN    = 1;
    localparam int          BIT_CLK_SEL   = 2;
    localparam int          BIT_FLAG      = 16;
    localparam logic [31:0] CTRL_RESET    = 32'h00000000;
    localparam logic [31:0] CALIB_VALUE   = 32'hc0000000;
    localparam logic [23:0] RELOAD_RESET  = 24'h000000;
    localparam logic [23:0] CURRENT_RESET = 24'h000000;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int REF_PERIOD_NS = 1000;
    localparam int REF_DIV_CYC   = (REF_PERIOD_NS < CLK_PERIOD_NS) ? 1 :
                                   REF_PERIOD_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic clock_select;
        logic tick_irq_enable;
        logic counter_enable;
    } tk_ctrl_t;

    typedef struct packed {
        logic [CNT_W-1:0] current;
        logic             reached_zero_flag;
    } tk_bank_t;

endpackage

// ===== src/tk_core.sv
// One banked 24-bit down counter with its reached-zero flag.
// Assumes tick_in is already gated by enable, clock select and halt.
`timescale 1ns/100ps

module tk_core #(
    parameter int CW = tk_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic          clk_sys_in,
    input  wire logic          resetn_in,
    // Control
    input  wire logic          tick_in,
    input  wire logic [CW-1:0] reload_in,
    input  wire logic          cvr_wr_in,
    input  wire logic          csr_rd_in,
    // State
    output tk_pkg::tk_bank_t   bank_out,
    output logic               wrap_out
);

    logic [CW-1:0] cur;
    logic          flag;
    logic [CW-1:0] next_cur;
    logic          next_flag;

    always_comb begin
        // A clearing write beats the count, so it never raises a request
        wrap_out  = tick_in && !cvr_wr_in && (cur == CW'(1));
        next_cur  = cur;
        next_flag = flag;
        if (cvr_wr_in) begin
            next_cur = '0;
        end else if (tick_in) begin
            if (cur == '0) begin
                next_cur = reload_in;
            end else begin
                next_cur = cur - CW'(1);
            end
        end
        if (cvr_wr_in || csr_rd_in) begin
            next_flag = 1'b0;
        end
        if (wrap_out) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cur  <= tk_pkg::CURRENT_RESET;
            flag <= 1'b0;
        end else begin
            cur  <= next_cur;
            flag <= next_flag;
        end
    end

    assign bank_out = '{current: cur, reached_zero_flag: flag};

endmodule // tk_core

// ===== src/tk_timer.sv
// Tick timer top: register port, banking, reference divider,
// request outputs and the summary interrupt.
// Assumes bus strobes are one cycle, never together, synchronous.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Contract
// - Enabled counter decrements, wraps to reload value
// - Secure and nonsecure banks, independent registers
// - Zero reload stops counting at next wrap
// - Transition to zero sets sticky flag
// - Control/status read clears the flag
// - Current write clears count, flag, no request
// - Debug halt freezes the counter
// - Clock select: 0 reference, 1 processor
// - Irq enable gates the tick request
// - Reload field bits 23:0, upper reserved
// - Flag and request only on 1 to 0
// - Current read returns live count
// - Calibration reads fixed no-ref, inexact, zero
// - Stopped controller clock halts counting
module tk_timer #(
    parameter int SEC_EXT = 1,
    parameter int CW      = tk_pkg::CNT_W,
    parameter int REF_DIV = tk_pkg::REF_DIV_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    // Register port
    input  wire logic [31:0] addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic        secure_in,
    output logic      [31:0] rdata_out,
    // Core status
    input  wire logic        debug_halt_in,
    input  wire logic        core_clk_run_in,
    // Requests
    output logic      [1:0]  tick_req_out,
    output logic             irq_out
);

    localparam int NB = (SEC_EXT != 0) ? 2 : 1;
    localparam int DW = (REF_DIV > 1) ? $clog2(REF_DIV) : 1;

    ////////////////////////////////////////////////////////////////////////
    // Bank select and access decode

    logic bsel;
    logic hit_ctrl;
    logic hit_reload;
    logic hit_current;

    // Without the security extension every access lands on bank 0
    assign bsel        = (NB == 2) ? secure_in : 1'b0;
    assign hit_ctrl    = (addr_in == tk_pkg::ADDR_CTRL_STATUS);
    assign hit_reload  = (addr_in == tk_pkg::ADDR_RELOAD);
    assign hit_current = (addr_in == tk_pkg::ADDR_CURRENT);

    ////////////////////////////////////////////////////////////////////////
    // Reference clock divider

    logic [DW-1:0] ref_cnt;
    logic [DW-1:0] next_ref_cnt;
    logic          ref_tick;
    logic          next_ref_tick;

    always_comb begin
        if (ref_cnt == DW'(REF_DIV - 1)) begin
            next_ref_cnt  = '0;
            next_ref_tick = 1'b1;
        end else begin
            next_ref_cnt  = ref_cnt + DW'(1);
            next_ref_tick = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ref_cnt  <= '0;
            ref_tick <= 1'b0;
        end else begin
            ref_cnt  <= next_ref_cnt;
            ref_tick <= next_ref_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Banks

    tk_pkg::tk_ctrl_t ctrl        [NB];
    tk_pkg::tk_ctrl_t next_ctrl   [NB];
    logic [CW-1:0]    reload      [NB];
    logic [CW-1:0]    next_reload [NB];
    tk_pkg::tk_bank_t bank        [NB];
    logic             tick        [NB];
    logic             cvr_wr      [NB];
    logic             csr_rd      [NB];
    logic             wrap        [NB];
    logic             req         [NB];

    genvar gb;
    generate
        for (gb = 0; gb < NB; gb++) begin : g_bank
            logic mine;
            logic src_tick;

            assign mine       = (bsel == 1'(gb));
            // Processor clock counts every cycle, reference only on its pulse
            assign src_tick   = ctrl[gb].clock_select ? 1'b1 : ref_tick;
            // Halt and a stopped controller clock both freeze the count
            assign tick[gb]   = ctrl[gb].counter_enable && src_tick
                                && !debug_halt_in && core_clk_run_in;
            assign cvr_wr[gb] = wr_in && hit_current && mine;
            assign csr_rd[gb] = rd_in && hit_ctrl && mine;
            assign req[gb]    = wrap[gb] && ctrl[gb].tick_irq_enable;

            always_comb begin
                next_ctrl[gb]   = ctrl[gb];
                next_reload[gb] = reload[gb];
                if (wr_in && mine && hit_ctrl) begin
                    next_ctrl[gb] = '{clock_select:    wdata_in[tk_pkg::BIT_CLK_SEL],
                                      tick_irq_enable: wdata_in[tk_pkg::BIT_IRQ_EN],
                                      counter_enable:  wdata_in[tk_pkg::BIT_ENABLE]};
                end
                if (wr_in && mine && hit_reload) begin
                    next_reload[gb] = wdata_in[CW-1:0];
                end
            end

            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    ctrl[gb]   <= tk_pkg::CTRL_RESET[2:0];
                    reload[gb] <= tk_pkg::RELOAD_RESET;
                end else begin
                    ctrl[gb]   <= next_ctrl[gb];
                    reload[gb] <= next_reload[gb];
                end
            end

            tk_core #(
                .CW (CW)
            ) u_core (
                .clk_sys_in (clk_sys_in),
                .resetn_in  (resetn_in),
                .tick_in    (tick[gb]),
                .reload_in  (reload[gb]),
                .cvr_wr_in  (cvr_wr[gb]),
                .csr_rd_in  (csr_rd[gb]),
                .bank_out   (bank[gb]),
                .wrap_out   (wrap[gb])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and outputs

    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] next_irq_stat;
    logic [1:0] next_irq_mask;
    logic [1:0] next_tick_req;
    logic       next_irq;

    always_comb begin
        next_tick_req = 2'h0;
        for (int b = 0; b < NB; b++) begin
            next_tick_req[b] = req[b];
        end
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        if (rd_in && addr_in == tk_pkg::ADDR_IRQ_STATUS) begin
            next_irq_stat = 2'h0;
        end
        // New events are kept even when the status read lands together
        next_irq_stat = next_irq_stat | next_tick_req;
        if (wr_in && addr_in == tk_pkg::ADDR_IRQ_MASK) begin
            next_irq_mask = wdata_in[1:0];
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_stat     <= 2'h0;
            irq_mask     <= 2'h0;
            tick_req_out <= 2'h0;
            irq_out      <= 1'b0;
        end else begin
            irq_stat     <= next_irq_stat;
            irq_mask     <= next_irq_mask;
            tick_req_out <= next_tick_req;
            irq_out      <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the read strobe

    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h00000000;
        if (rd_in) begin
            case (addr_in)
                tk_pkg::ADDR_CTRL_STATUS: begin
                    next_rdata[tk_pkg::BIT_FLAG]    = bank[bsel].reached_zero_flag;
                    next_rdata[tk_pkg::BIT_CLK_SEL] = ctrl[bsel].clock_select;
                    next_rdata[tk_pkg::BIT_IRQ_EN]  = ctrl[bsel].tick_irq_enable;
                    next_rdata[tk_pkg::BIT_ENABLE]  = ctrl[bsel].counter_enable;
                end
                tk_pkg::ADDR_RELOAD: begin
                    next_rdata[CW-1:0] = reload[bsel];
                end
                tk_pkg::ADDR_CURRENT: begin
                    next_rdata[CW-1:0] = bank[bsel].current;
                end
                tk_pkg::ADDR_CALIB: begin
                    next_rdata = tk_pkg::CALIB_VALUE;
                end
                tk_pkg::ADDR_IRQ_STATUS: begin
                    next_rdata[1:0] = irq_stat;
                end
                tk_pkg::ADDR_IRQ_MASK: begin
                    next_rdata[1:0] = irq_mask;
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= 32'h00000000;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on bank 0

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    decrement_step_a: assert property (
        tick[0] && !cvr_wr[0] && bank[0].current != '0
        |=> bank[0].current == $past(bank[0].current) - CW'(1))
        else $error("counter did not step down by one");

    wrap_reload_a: assert property (
        tick[0] && !cvr_wr[0] && bank[0].current == '0
        |=> bank[0].current == $past(reload[0]))
        else $error("counter did not take the reload value");

    flag_set_a: assert property (
        tick[0] && !cvr_wr[0] && bank[0].current == CW'(1)
        |=> bank[0].reached_zero_flag && bank[0].current == '0)
        else $error("reaching zero did not set the flag");

    read_clear_a: assert property (
        csr_rd[0] && !wrap[0] |=> !bank[0].reached_zero_flag)
        else $error("status read did not clear the flag");

    read_set_wins_a: assert property (
        csr_rd[0] && wrap[0] |=> bank[0].reached_zero_flag)
        else $error("coinciding read lost the flag");

    current_clear_a: assert property (
        cvr_wr[0] |=> bank[0].current == '0 && !bank[0].reached_zero_flag
        && tick_req_out[0] == 1'b0)
        else $error("current write did not clear or raised a request");

    halt_hold_a: assert property (
        (debug_halt_in || !core_clk_run_in) && !cvr_wr[0]
        |=> $stable(bank[0].current))
        else $error("counter moved while halted");

    ref_select_a: assert property (
        ctrl[0].counter_enable && !ctrl[0].clock_select && !ref_tick
        && !cvr_wr[0] |=> $stable(bank[0].current))
        else $error("reference mode counted without a reference pulse");

    request_gate_a: assert property (
        tick_req_out[0] |-> $past(wrap[0] && ctrl[0].tick_irq_enable))
        else $error("tick request without an enabled zero event");

    calib_read_a: assert property (
        rd_in && addr_in == tk_pkg::ADDR_CALIB |=> rdata_out == tk_pkg::CALIB_VALUE)
        else $error("calibration read returned the wrong value");

    current_read_a: assert property (
        rd_in && hit_current && !bsel
        |=> rdata_out == {8'h00, $past(bank[0].current)})
        else $error("current read returned a stale value");

    flag_origin_a: assert property (
        $rose(bank[0].reached_zero_flag)
        |-> bank[0].current == '0 && $past(bank[0].current) == CW'(1))
        else $error("flag rose without a count from one to zero");

    reload_write_a: assert property (
        wr_in && hit_reload && !bsel |=> reload[0] == $past(wdata_in[CW-1:0]))
        else $error("reload write did not land");

    reserved_zero_a: assert property (
        rd_in && (hit_reload || hit_current) |=> rdata_out[31:24] == 8'h00)
        else $error("reserved bits did not read zero");

    bank_isolate_a: assert property (
        wr_in && bsel |=> $stable(ctrl[0]) && $stable(reload[0]))
        else $error("secure write disturbed the nonsecure bank");

    ctrl_read_a: assert property (
        csr_rd[0] |=> rdata_out[tk_pkg::BIT_FLAG] == $past(bank[0].reached_zero_flag))
        else $error("status read did not return the flag");

    proc_clock_a: assert property (
        ctrl[0].counter_enable && ctrl[0].clock_select && !debug_halt_in
        && core_clk_run_in && !cvr_wr[0] && bank[0].current != '0
        |=> bank[0].current != $past(bank[0].current))
        else $error("processor clock mode skipped a count");

    status_set_a: assert property (
        tick_req_out[0] |-> irq_stat[0])
        else $error("tick request did not set its status bit");

    clock_stop_a: assert property (
        !core_clk_run_in && !cvr_wr[0]
        |=> $stable(bank[0].current) && !tick_req_out[0])
        else $error("counter moved while the controller clock was stopped");

    wrap_cover_c: cover property (wrap[0] && ctrl[0].tick_irq_enable ##1 tick_req_out[0]);
    zero_stop_c: cover property (tick[0] && bank[0].current == '0 && reload[0] == '0);
    read_race_c: cover property (csr_rd[0] && wrap[0]);
    halt_c: cover property (ctrl[0].counter_enable && debug_halt_in);

endmodule // tk_timer

// ===== test/tk_timer_bench.sv
// Self-checking bench for the tick timer: register tasks and scenario list.
// Assumes tk_pkg and tk_timer are compiled first; bank 1 is secure.
`timescale 1ns/100ps

module tk_timer_bench;

    // Short reference period keeps the slow-clock scenario brief
    localparam int REF_DIV = 2;

    logic        clk_sys_in;
    logic        resetn_in;
    logic [31:0] addr_in;
    logic [31:0] wdata_in;
    logic        wr_in;
    logic        rd_in;
    logic        secure_in;
    logic [31:0] rdata_out;
    logic        debug_halt_in;
    logic        core_clk_run_in;
    logic [1:0]  tick_req_out;
    logic        irq_out;
    int          failures;
    int          compares;
    int          cyc;
    int          n_req [2];
    int          t1;
    int          t2;
    int          n0;
    logic [31:0] a;
    logic [31:0] b;

    tk_timer #(.SEC_EXT(1), .CW(tk_pkg::CNT_W), .REF_DIV(REF_DIV)) uut (
        .clk_sys_in      (clk_sys_in),
        .resetn_in       (resetn_in),
        .addr_in         (addr_in),
        .wdata_in        (wdata_in),
        .wr_in           (wr_in),
        .rd_in           (rd_in),
        .secure_in       (secure_in),
        .rdata_out       (rdata_out),
        .debug_halt_in   (debug_halt_in),
        .core_clk_run_in (core_clk_run_in),
        .tick_req_out    (tick_req_out),
        .irq_out         (irq_out)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    // Pulses are counted at the falling edge, clear of the launching edge
    always @(negedge clk_sys_in) begin
        if (tick_req_out[0] === 1'b1) n_req[0]++;
        if (tick_req_out[1] === 1'b1) n_req[1]++;
    end

    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] ad, input logic [31:0] d, input logic s);
        @(posedge clk_sys_in);
        wr_in     <= 1'b1;
        addr_in   <= ad;
        wdata_in  <= d;
        secure_in <= s;
        @(posedge clk_sys_in);
        wr_in     <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] ad, input logic s, output logic [31:0] d);
        @(posedge clk_sys_in);
        rd_in     <= 1'b1;
        addr_in   <= ad;
        secure_in <= s;
        @(posedge clk_sys_in);
        rd_in     <= 1'b0;
        #1;
        d = rdata_out;
    endtask

    task automatic rdchk(input logic [31:0] ad, input logic s, input logic [31:0] exp);
        logic [31:0] d;
        rd(ad, s, d);
        chk(d, exp);
    endtask

    // Bounded wait for the next request pulse of one bank
    task automatic wait_pulse(input int bk, output int t);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(negedge clk_sys_in);
            if (tick_req_out[bk] === 1'b1) break;
        end
        t = cyc;
        if (i == 3000) chk(32'h1, 32'h0);
    endtask

    // Software start-up order: reload, clear current, then control
    task automatic start(input logic [31:0] rl, input logic [31:0] ctl, input logic s);
        wr(tk_pkg::ADDR_RELOAD, rl, s);
        wr(tk_pkg::ADDR_CURRENT, 32'h5a5a5a5a, s);
        wr(tk_pkg::ADDR_CTRL_STATUS, ctl, s);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        compares = 0;
        cyc = 0;
        resetn_in = 1'b0;
        addr_in = 32'h00000000;
        wdata_in = 32'h00000000;
        wr_in = 1'b0;
        rd_in = 1'b0;
        secure_in = 1'b0;
        debug_halt_in = 1'b0;
        core_clk_run_in = 1'b1;
        repeat (12) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        // Reset values, fixed calibration word, unmapped place
        rdchk(tk_pkg::ADDR_CTRL_STATUS, 1'b1, 32'h00000000);
        wr(tk_pkg::ADDR_CALIB, 32'h00000000, 1'b0);
        rdchk(tk_pkg::ADDR_CALIB, 1'b0, 32'hc0000000);
        rdchk(tk_pkg::ADDR_CALIB, 1'b1, 32'hc0000000);
        wr(32'he000e028, 32'hffffffff, 1'b1);
        rdchk(32'he000e028, 1'b1, 32'h00000000);
        wr(tk_pkg::ADDR_IRQ_MASK, 32'h00000002, 1'b1);
        rdchk(tk_pkg::ADDR_IRQ_MASK, 1'b1, 32'h00000002);
        // Reserved reload bits, period N for reload N-1, interrupt
        start(32'hff000002, 32'h00000007, 1'b1);
        rdchk(tk_pkg::ADDR_RELOAD, 1'b1, 32'h00000002);
        wait_pulse(1, t1);
        wait_pulse(1, t2);
        chk(32'(t2 - t1), 32'd3);
        chk({31'h0, irq_out}, 32'h1);
        wr(tk_pkg::ADDR_CTRL_STATUS, 32'h00000006, 1'b1);
        rdchk(tk_pkg::ADDR_CTRL_STATUS, 1'b1, 32'h00010006);
        rdchk(tk_pkg::ADDR_CTRL_STATUS, 1'b1, 32'h00000006);
        rdchk(tk_pkg::ADDR_IRQ_STATUS, 1'b1, 32'h00000002);
        chk({31'h0, irq_out}, 32'h0);
        // Other bank untouched by all of the above
        rdchk(tk_pkg::ADDR_RELOAD, 1'b0, 32'h00000000);
        rdchk(tk_pkg::ADDR_CTRL_STATUS, 1'b0, 32'h00000000);
        chk(32'(n_req[0]), 32'h0);
        // Current write lands on the 1 to 0 edge: cleared, no flag, no request
        start(32'h00000002, 32'h00000007, 1'b0);
        wait_pulse(0, t1);
        @(posedge clk_sys_in);
        n0 = n_req[0];
        wr(tk_pkg::ADDR_CURRENT, 32'h00000001, 1'b0);
        @(posedge clk_sys_in);
        chk(32'(n_req[0] - n0), 32'h0);
        // This read meets the next zero edge, so the new flag must survive it
        rdchk(tk_pkg::ADDR_CTRL_STATUS, 1'b0, 32'h00000007);
        rdchk(tk_pkg::ADDR_CTRL_STATUS, 1'b0, 32'h00010007);
        wr(tk_pkg::ADDR_CTRL_STATUS, 32'h00000006, 1'b0);
        rdchk(tk_pkg::ADDR_CTRL_STATUS, 1'b0, 32'h00010006);
        rdchk(tk_pkg::ADDR_CTRL_STATUS, 1'b0, 32'h00000006);
        wr(tk_pkg::ADDR_CURRENT, 32'h00000001, 1'b0);
        rdchk(tk_pkg::ADDR_CURRENT, 1'b0, 32'h00000000);
        // No request with the irq enable low, flag still set
        start(32'h00000002, 32'h00000005, 1'b1);
        n0 = n_req[1];
        repeat (20) @(posedge clk_sys_in);
        wr(tk_pkg::ADDR_CTRL_STATUS, 32'h00000004, 1'b1);
        chk(32'(n_req[1] - n0), 32'h0);
        rdchk(tk_pkg::ADDR_CTRL_STATUS, 1'b1, 32'h00010004);
        // Reference clock counts once per divider period
        start(32'h00000003, 32'h00000003, 1'b0);
        wait_pulse(0, t1);
        wait_pulse(0, t2);
        chk(32'(t2 - t1), 32'(4 * REF_DIV));
        // Live reads, frozen by halt and by a stopped controller clock
        start(32'h000003e8, 32'h00000005, 1'b0);
        rd(tk_pkg::ADDR_CURRENT, 1'b0, a);
        rd(tk_pkg::ADDR_CURRENT, 1'b0, b);
        chk(a - b, 32'h2);
        chk({24'h000000, a[31:24]}, 32'h0);
        debug_halt_in <= 1'b1;
        rd(tk_pkg::ADDR_CURRENT, 1'b0, a);
        repeat (10) @(posedge clk_sys_in);
        rdchk(tk_pkg::ADDR_CURRENT, 1'b0, a);
        debug_halt_in <= 1'b0;
        core_clk_run_in <= 1'b0;
        rd(tk_pkg::ADDR_CURRENT, 1'b0, a);
        repeat (10) @(posedge clk_sys_in);
        rdchk(tk_pkg::ADDR_CURRENT, 1'b0, a);
        core_clk_run_in <= 1'b1;
        // Zero reload: counter rests at zero, no flag, no request
        start(32'h00000000, 32'h00000007, 1'b0);
        n0 = n_req[0];
        repeat (20) @(posedge clk_sys_in);
        rdchk(tk_pkg::ADDR_CTRL_STATUS, 1'b0, 32'h00000007);
        rdchk(tk_pkg::ADDR_CURRENT, 1'b0, 32'h00000000);
        chk(32'(n_req[0] - n0), 32'h0);
        final_report();
    end

endmodule // tk_timer_bench
